// ---- include/crc_gen_map.svh ----
// constants for the crc generator: polynomials, seeds, source codes, flash range
// assumes it is included by the design files by bare name
`ifndef CRC_GEN_MAP_SVH
`define CRC_GEN_MAP_SVH
`define CRC_POLY16 32'h0000_1021
`define CRC_POLY32 32'h04C1_1DB7
`define CRC_SEED16 32'h0000_FFFF
`define CRC_SEED32 32'hFFFF_FFFF
`define CRC_MASK16 32'h0000_FFFF
`define CRC_MASK32 32'hFFFF_FFFF
`define CRC_ZERO_BYTE16 32'h0000_E1F0
`define CRC_ZERO_BYTE32 32'h4E08_BFB4
`define CRC_SRC_CPU 2'h0
`define CRC_SRC_DMA 2'h1
`define CRC_SRC_FLASH 2'h2
`define CRC_FLASH_LAST 24'h01_FFFF
`define CRC_FLASH_FIRST 24'h00_0000
`endif

// ---- include/crc_gen_pkg.sv ----
// types shared by the crc generator files
// assumes crc_gen_map.svh sits in the include path
package crc_gen_pkg;
  typedef enum logic [1:0] {
    SRC_CPU = 2'b00,
    SRC_DMA = 2'b01,
    SRC_FLASH = 2'b10,
    SRC_OFF = 2'b11
  } src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } fstate_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;

  typedef struct packed {
    logic poly32;
    logic [1:0] src;
    logic full_flash;
    logic [23:0] first;
    logic [23:0] last;
  } cfg_t;
endpackage

// ---- verilog/crc_byte_step.sv ----
// one-byte crc update for both polynomials, msb first, non-reflected
// assumes the caller registers the result; purely combinational
`timescale 1ns/100ps
`include "crc_gen_map.svh"
module crc_byte_step (
  input wire logic poly32_i,
  input wire logic [31:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [31:0] crc_o
);
  logic [31:0] poly;
  logic [31:0] mask;
  logic [31:0] stage [0:8];

  assign poly = poly32_i ? `CRC_POLY32 : `CRC_POLY16;
  assign mask = poly32_i ? `CRC_MASK32 : `CRC_MASK16;
  assign stage[0] = crc_i & mask;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      logic top;
      logic [31:0] shifted;
      assign top = (poly32_i ? stage[b][31] : stage[b][15]) ^ data_i[7-b];
      assign shifted = {stage[b][30:0], 1'b0};
      assign stage[b+1] = (shifted ^ (top ? poly : 32'h0000_0000)) & mask;
    end
  endgenerate

  assign crc_o = stage[8];
endmodule

// ---- verilog/crc_gen.sv ----
// crc generator with cpu, dma-snoop and autonomous flash-read sources
// assumes dma and flash ports are on clk_i; the flash answers a read with one rvalid pulse
`timescale 1ns/100ps
`include "crc_gen_map.svh"
module crc_gen #(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire crc_gen_pkg::cfg_t cfg_i,
  input wire logic clear_i,
  input wire logic start_flash_i,
  input wire crc_gen_pkg::byte_beat_t cpu_i,
  input wire crc_gen_pkg::byte_beat_t dma_i,
  input wire logic [7:0] flash_rdata_i,
  input wire logic flash_rvalid_i,
  output logic flash_req_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [31:0] checksum_o,
  output logic zero_o,
  output logic busy_o
);
  logic [31:0] crc;
  logic [31:0] next_crc;
  logic [31:0] step_out;
  logic [31:0] seed;
  logic poly32;
  logic [1:0] src;
  crc_gen_pkg::fstate_t state;
  crc_gen_pkg::fstate_t next_state;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] first_addr;
  logic [ADDR_W-1:0] last_addr;
  logic [ADDR_W-1:0] next_addr;
  logic beat;
  logic [7:0] beat_data;
  logic flash_beat;
  logic at_last;

  assign poly32 = cfg_i.poly32;
  assign src = cfg_i.src;
  assign seed = poly32 ? `CRC_SEED32 : `CRC_SEED16;
  assign first_addr = cfg_i.full_flash ? ADDR_W'(`CRC_FLASH_FIRST)
                                       : cfg_i.first[ADDR_W-1:0];
  assign last_addr = cfg_i.full_flash ? ADDR_W'(`CRC_FLASH_LAST)
                                      : cfg_i.last[ADDR_W-1:0];
  assign flash_beat = (state == crc_gen_pkg::ST_WAIT) && flash_rvalid_i;
  assign at_last = (addr == last_addr);

  // source mux: only the selected source may move the remainder
  assign beat = (src == `CRC_SRC_CPU && cpu_i.valid)
             || (src == `CRC_SRC_DMA && dma_i.valid)
             || (src == `CRC_SRC_FLASH && flash_beat);
  assign beat_data = (src == `CRC_SRC_DMA) ? dma_i.data
                   : (src == `CRC_SRC_FLASH) ? flash_rdata_i : cpu_i.data;

  crc_byte_step u_step (
    .poly32_i(poly32),
    .crc_i(crc),
    .data_i(beat_data),
    .crc_o(step_out)
  );

  // clear beats data in the same cycle: software restarts a block explicitly
  assign next_crc = clear_i ? seed : (beat ? step_out : crc);

  always_comb begin
    next_state = state;
    next_addr = addr;
    case (state)
      crc_gen_pkg::ST_IDLE: begin
        if (start_flash_i && src == `CRC_SRC_FLASH) begin
          next_state = crc_gen_pkg::ST_REQ;
          next_addr = first_addr;
        end
      end
      crc_gen_pkg::ST_REQ: next_state = crc_gen_pkg::ST_WAIT;
      crc_gen_pkg::ST_WAIT: begin
        if (flash_rvalid_i) begin
          if (at_last) begin
            next_state = crc_gen_pkg::ST_DONE;
          end else begin
            next_state = crc_gen_pkg::ST_REQ;
            next_addr = addr + ADDR_W'(1);
          end
        end
      end
      crc_gen_pkg::ST_DONE: next_state = crc_gen_pkg::ST_IDLE;
      default: next_state = crc_gen_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc <= `CRC_SEED16;
      state <= crc_gen_pkg::ST_IDLE;
      addr <= '0;
    end else begin
      crc <= next_crc;
      state <= next_state;
      addr <= next_addr;
    end
  end

  // outputs registered so that consumers see a stable result
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // matches the remainder so the first edge after reset shows no jump
      checksum_o <= `CRC_SEED16;
      zero_o <= 1'b0;
      busy_o <= 1'b0;
      flash_req_o <= 1'b0;
      flash_addr_o <= '0;
    end else begin
      checksum_o <= next_crc;
      zero_o <= (next_crc == 32'h0000_0000);
      busy_o <= (next_state != crc_gen_pkg::ST_IDLE);
      flash_req_o <= (next_state == crc_gen_pkg::ST_REQ);
      flash_addr_o <= next_addr;
    end
  end

  // assertions
  property p_width16;
    @(posedge clk_i) disable iff (!rst_n_i)
      !poly32 |=> (checksum_o[31:16] == 16'h0000);
  endproperty
  a_width16: assert property (p_width16) else $error("16-bit checksum has upper bits set");

  property p_cpu_step;
    @(posedge clk_i) disable iff (!rst_n_i)
      (src == `CRC_SRC_CPU && cpu_i.valid && !clear_i) |=> (checksum_o == $past(step_out));
  endproperty
  a_cpu_step: assert property (p_cpu_step) else $error("cpu byte did not update crc");

  property p_dma_step;
    @(posedge clk_i) disable iff (!rst_n_i)
      (src == `CRC_SRC_DMA && dma_i.valid && !clear_i) |=> (checksum_o == $past(step_out));
  endproperty
  a_dma_step: assert property (p_dma_step) else $error("dma byte did not update crc");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!beat && !clear_i) |=> $stable(checksum_o);
  endproperty
  a_hold: assert property (p_hold) else $error("crc moved without data");

  property p_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> (zero_o == (checksum_o == 32'h0000_0000));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  // a zero byte on a fresh seed gives a fixed remainder for each polynomial
  property p_poly16;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!poly32 && crc == `CRC_SEED16 && beat_data == 8'h00 && beat && !clear_i)
        |=> (crc == `CRC_ZERO_BYTE16);
  endproperty
  a_poly16: assert property (p_poly16) else $error("ccitt division wrong");

  property p_poly32;
    @(posedge clk_i) disable iff (!rst_n_i)
      (poly32 && crc == `CRC_SEED32 && beat_data == 8'h00 && beat && !clear_i)
        |=> (crc == `CRC_ZERO_BYTE32);
  endproperty
  a_poly32: assert property (p_poly32) else $error("ethernet division wrong");

  property p_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      clear_i |=> (checksum_o == ($past(poly32) ? `CRC_SEED32 : `CRC_SEED16));
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not load the seed");

  sequence s_flash_req;
    flash_req_o;
  endsequence
  sequence s_flash_more;
    state == crc_gen_pkg::ST_WAIT && flash_rvalid_i && !at_last;
  endsequence
  sequence s_flash_last;
    state == crc_gen_pkg::ST_WAIT && flash_rvalid_i && at_last;
  endsequence
  property p_flash_seq;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_flash_req |=> !flash_req_o;
  endproperty
  a_flash_seq: assert property (p_flash_seq) else $error("flash request longer than a cycle");

  property p_flash_next;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_flash_more |=> (flash_req_o && flash_addr_o == $past(addr) + ADDR_W'(1));
  endproperty
  a_flash_next: assert property (p_flash_next) else $error("flash scan did not step");

  property p_flash_done;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_flash_last |=> busy_o ##1 !busy_o;
  endproperty
  a_flash_done: assert property (p_flash_done) else $error("flash scan did not end");

  property p_flash_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state == crc_gen_pkg::ST_WAIT && !flash_rvalid_i) |=> !flash_req_o;
  endproperty
  a_flash_wait: assert property (p_flash_wait) else $error("flash request while waiting");

  property p_select;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_flash_i && state == crc_gen_pkg::ST_IDLE && src == `CRC_SRC_FLASH)
        |=> (flash_req_o && flash_addr_o == $past(first_addr));
  endproperty
  a_select: assert property (p_select) else $error("flash read did not start at range start");

  property p_start_refused;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_flash_i && state == crc_gen_pkg::ST_IDLE && src != `CRC_SRC_FLASH)
        |=> !busy_o;
  endproperty
  a_start_refused: assert property (p_start_refused) else $error("scan started off flash");

  property p_busy_start;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_flash_i && state == crc_gen_pkg::ST_IDLE && src == `CRC_SRC_FLASH)
        |=> busy_o;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy missing at scan start");
endmodule

// ---- verification/flash_model.sv ----
// flash array model: answers each read request after one or four idle cycles
// assumes one request at a time, on clk_i
`timescale 1ns/100ps
module flash_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [23:0] addr_i,
  input wire logic slow_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o
);
  logic [2:0] cnt;
  logic [7:0] val;
  // idle data toggles so a stale byte never looks fresh
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 3'h0;
      val <= 8'h00;
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= cnt == 3'h1;
      rdata_o <= (cnt == 3'h1) ? val : ~rdata_o;
      if (req_i) begin
        cnt <= slow_i ? 3'h4 : 3'h1;
        val <= addr_i[7:0] ^ 8'h5a;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for crc_gen: cpu, dma and flash sources, both polynomials
// assumes flash_model as the flash; sums come from a bench-side bitwise model
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  crc_gen_pkg::cfg_t cfg_i = '0;
  logic clear_i = 1'b0;
  logic start_flash_i = 1'b0;
  crc_gen_pkg::byte_beat_t cpu_i = '0;
  crc_gen_pkg::byte_beat_t dma_i = '0;
  logic [7:0] flash_rdata_i;
  logic flash_rvalid_i, flash_req_o, zero_o, busy_o;
  logic slow = 1'b0;
  logic v1 = 1'b0;
  logic [23:0] flash_addr_o;
  logic [23:0] fa = '0;
  logic [31:0] checksum_o, crc;
  logic [31:0] x = 32'h0000_c6cf;
  logic [32:0] q[$];
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  wire taken = cfg_i.src == 2'h0 ? cpu_i.valid : cfg_i.src == 2'h1 ? dma_i.valid :
    cfg_i.src == 2'h2 && flash_rvalid_i;

  always #50 clk_i = ~clk_i;

  crc_gen i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i), .clear_i(clear_i),
    .start_flash_i(start_flash_i), .cpu_i(cpu_i), .dma_i(dma_i),
    .flash_rdata_i(flash_rdata_i), .flash_rvalid_i(flash_rvalid_i),
    .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o), .checksum_o(checksum_o),
    .zero_o(zero_o), .busy_o(busy_o));
  flash_model i_flash (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(flash_req_o),
    .addr_i(flash_addr_o), .slow_i(slow), .rdata_o(flash_rdata_i),
    .rvalid_o(flash_rvalid_i));

  function automatic logic [31:0] upd(input logic p, input logic [31:0] c,
    input logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = (p ? c[31] : c[15]) ^ d[i];
      c = c << 1;
      if (fb) c = c ^ (p ? 32'h04c1_1db7 : 32'h0000_1021);
    end
    return p ? c : {16'h0000, c[15:0]};
  endfunction

  function automatic logic [7:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x[7:0];
  endfunction

  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // the note is taken off when the byte's result shows, one cycle after taking
  always @(posedge clk_i) begin
    if (v1) chk("checksum", q.pop_front(), {checksum_o, zero_o});
    if (flash_req_o) begin
      chk("flash_addr", {9'h000, fa}, {9'h000, flash_addr_o});
      fa <= fa + 24'h00_0001;
    end
    v1 <= taken;
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic note(input logic [7:0] d);
    crc = upd(cfg_i.poly32, crc, d);
    q.push_back({crc, crc == 32'h0000_0000});
  endtask

  task automatic clr();
    @(posedge clk_i);
    clear_i <= 1'b1;
    start_flash_i <= 1'b0;
    @(posedge clk_i);
    clear_i <= 1'b0;
    crc = cfg_i.poly32 ? 32'hffff_ffff : 32'h0000_ffff;
  endtask

  // the unselected source carries other bytes at the same time; it must be ignored
  task automatic send(input logic [7:0] d);
    @(posedge clk_i);
    cpu_i <= {1'b1, cfg_i.src[0] ? ~d : d};
    dma_i <= {1'b1, cfg_i.src[0] ? d : ~d};
    note(d);
  endtask

  task automatic run_bus(input logic p, input logic s);
    logic [31:0] k;
    @(posedge clk_i);
    cfg_i.poly32 <= p;
    cfg_i.src <= {1'b0, s};
    start_flash_i <= 1'b1; // outside flash mode this start must be refused
    clr();
    chk("busy_refused", 33'h0_0000_0000, {32'h0000_0000, busy_o});
    send(8'h00);
    repeat (6) send(rnd());
    k = crc;
    for (int i = p ? 3 : 1; i >= 0; i--) send(k[8*i+:8]);
    @(posedge clk_i);
    cpu_i.valid <= 1'b0;
    dma_i.valid <= 1'b0;
    repeat (3) @(posedge clk_i);
    $display("bus test poly32=%0d dma=%0d done", p, s);
  endtask

  task automatic run_flash(input logic p);
    int n = 0;
    @(posedge clk_i);
    cfg_i <= {p, 2'h2, 1'b0, 24'h00_0010, 24'h00_0014};
    slow <= p;
    clr();
    fa = 24'h00_0010;
    for (int a = 16; a <= 20; a++) note(a[7:0] ^ 8'h5a);
    @(posedge clk_i);
    start_flash_i <= 1'b1;
    @(posedge clk_i);
    start_flash_i <= 1'b0;
    @(posedge clk_i);
    chk("busy", 33'h0_0000_0001, {32'h0000_0000, busy_o});
    while (busy_o === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("busy_end", 33'h0_0000_0000, {32'h0000_0000, busy_o});
    repeat (3) @(posedge clk_i);
    chk("flash_end", {9'h000, 24'h00_0015}, {q.size() != 0, 8'h00, fa});
    $display("flash test poly32=%0d done", p);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("reset_sum", {32'h0000_ffff, 1'b0}, {checksum_o, zero_o});
    for (int m = 0; m < 4; m++) run_bus(m[1], m[0]);
    for (int m = 0; m < 2; m++) run_flash(m[0]);
    give_verdict();
  end
endmodule
